/* hdl/bit_test_defines.vh */
// constants for the serial bit-test-even sequencer
`ifndef BIT_TEST_DEFINES_VH
`define BIT_TEST_DEFINES_VH
`define ACC_WIDTH 24
`define ACC_MSB 23
`define IDX_WIDTH 5
`define CNT_TERMINAL 5'h1f
`define SHIFT_COUNT 5'h18
`define ACC_RESET 24'h000000
`define CNT_RESET 5'h00
`define PC_RESET 15'h0000
`endif

/* hdl/serial_full_adder.v */
// one-bit serial full adder with registered carry
`timescale 1ns/10ps
module serial_full_adder (
   input wire core_clk, // machine clock
   input wire resetn, // async reset, active low
   input wire carryHold, // forces carry flag set
   input wire addA, // adder a input
   input wire addB, // adder b input
   output wire sumOut, // sum of a, b and carry
   output reg serialCarryFlag_reg // carry flag
);
   wire carryNext;
   assign sumOut = addA ^ addB ^ serialCarryFlag_reg;
   assign carryNext = carryHold | (addA & addB) | (addA & serialCarryFlag_reg) |
                      (addB & serialCarryFlag_reg);
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn)
         serialCarryFlag_reg <= 1'b0;
      else
         serialCarryFlag_reg <= carryNext;
   end
endmodule // serial_full_adder

/* hdl/serial_bit_test_even.v */
// sequencer for the serial bit-test-even instruction
`timescale 1ns/10ps
`include "bit_test_defines.vh"
module serial_bit_test_even (
   input wire core_clk, // machine clock
   input wire resetn, // async reset, active low
   input wire test_bit_even_op, // one-cycle start pulse, control state 4
   input wire [4:0] instruction_index_field, // selected bit index
   input wire accLoad, // load accumulator from accIn when idle
   input wire [23:0] accIn, // accumulator load value
   input wire [14:0] pcIn, // program counter value at start
   output reg [23:0] acc_reg, // accumulator
   output reg test_flag, // test flag
   output reg [4:0] shiftCount_reg, // shift counter
   output reg [14:0] pc_reg, // program counter
   output reg busy_reg, // instruction running
   output reg done_reg, // one-cycle completion pulse
   output reg serial_carry_flag // copy of adder carry flag
);
   // ****************************************
   // state and declarations
   // ****************************************
   localparam IDLE = 1'b0;
   localparam SHIFT = 1'b1;
   reg state_reg;
   reg state_next;
   reg [4:0] shifts_reg;
   reg [4:0] shifts_next;
   // next values of the output flops
   reg [23:0] acc_next;
   reg testFlag_next;
   reg [4:0] shiftCount_next;
   reg [14:0] pc_next;
   reg busy_next;
   reg done_next;
   reg carryCopy_next;
   // adder and decode nets
   wire sumOut;
   wire carryFlag;
   wire carryHold;
   wire adderA;
   wire adderB;
   wire startNow;
   wire lastShift;
   wire atSelected;

   // ****************************************
   // helper functions
   // ****************************************
   // five-bit increment that wraps like the hardware counter
   function [4:0] inc5;
      input [4:0] v;
      begin
         inc5 = v + 5'h01;
      end
   endfunction

   // one right shift with the adder sum entering the top bit
   function [23:0] shiftIn;
      input [23:0] v;
      input topBit;
      begin
         shiftIn = {topBit, v[`ACC_MSB:1]};
      end
   endfunction

   // counter value at which the selected bit sits in the lsb
   function isTerminal;
      input [4:0] v;
      begin
         isTerminal = (v == `CNT_TERMINAL);
      end
   endfunction

   // program counter step at the end of the instruction
   function [14:0] nextPc;
      input [14:0] v;
      begin
         nextPc = v + 15'h0001;
      end
   endfunction

   // ****************************************
   // serial adder
   // ****************************************
   // inverted lsb plus the held carry gives back the true lsb
   assign adderA = ~acc_reg[0];
   // b input stays disabled for this instruction
   assign adderB = 1'b0;
   // carry forced from the start edge to the last shift
   assign carryHold = busy_reg | startNow;
   serial_full_adder adder (
      .core_clk(core_clk),
      .resetn(resetn),
      .carryHold(carryHold),
      .addA(adderA),
      .addB(adderB),
      .sumOut(sumOut),
      .serialCarryFlag_reg(carryFlag)
   );

   // ****************************************
   // decode
   // ****************************************
   // start is taken only while idle; busy follows the state
   assign startNow = (state_reg == IDLE) && test_bit_even_op;
   // a separate count of shifts ends the run, whatever the index
   assign lastShift = (shifts_reg == (`SHIFT_COUNT - 5'h01));
   assign atSelected = (state_reg == SHIFT) && isTerminal(shiftCount_reg);

   // ****************************************
   // datapath next values
   // ****************************************
   always @* begin
      acc_next = acc_reg;
      shiftCount_next = shiftCount_reg;
      testFlag_next = test_flag;
      case (state_reg)
         IDLE: begin
            // start wins over a load in the same cycle
            if (test_bit_even_op) begin
               shiftCount_next = ~instruction_index_field;
               testFlag_next = 1'b0;
            end else if (accLoad) begin
               acc_next = accIn;
            end
         end
         SHIFT: begin
            // rotate: the sum equals the true lsb, so no bit is lost
            acc_next = shiftIn(acc_reg, sumOut);
            shiftCount_next = inc5(shiftCount_reg);
            // only the shift that brings the selected bit down may set the flag
            if (atSelected && !acc_reg[0]) begin
               testFlag_next = 1'b1;
            end else if (atSelected) begin
               testFlag_next = test_flag;
            end
         end
         default: begin
            acc_next = acc_reg;
         end
      endcase
   end

   // ****************************************
   // control next values
   // ****************************************
   always @* begin
      state_next = state_reg;
      shifts_next = shifts_reg;
      pc_next = pc_reg;
      busy_next = busy_reg;
      // done stands for one cycle only
      done_next = 1'b0;
      carryCopy_next = carryFlag | busy_reg;
      case (state_reg)
         IDLE: begin
            // pc is captured at start and stepped once at the end
            if (test_bit_even_op) begin
               pc_next = pcIn;
               shifts_next = `CNT_RESET;
               busy_next = 1'b1;
               carryCopy_next = 1'b1;
               state_next = SHIFT;
            end
         end
         SHIFT: begin
            // the run length does not depend on the index
            shifts_next = inc5(shifts_reg);
            if (lastShift) begin
               pc_next = nextPc(pc_reg);
               busy_next = 1'b0;
               done_next = 1'b1;
               state_next = IDLE;
            end
         end
         default: begin
            state_next = IDLE;
            busy_next = 1'b0;
         end
      endcase
   end

   // ****************************************
   // registers
   // ****************************************
   // every output of the block comes straight from one of these flops
   always @(posedge core_clk or negedge resetn) begin
      if (!resetn) begin
         state_reg <= IDLE;
         acc_reg <= `ACC_RESET;
         test_flag <= 1'b0;
         shiftCount_reg <= `CNT_RESET;
         pc_reg <= `PC_RESET;
         busy_reg <= 1'b0;
         done_reg <= 1'b0;
         shifts_reg <= `CNT_RESET;
         serial_carry_flag <= 1'b0;
      end else begin
         state_reg <= state_next;
         acc_reg <= acc_next;
         test_flag <= testFlag_next;
         shiftCount_reg <= shiftCount_next;
         pc_reg <= pc_next;
         busy_reg <= busy_next;
         done_reg <= done_next;
         shifts_reg <= shifts_next;
         serial_carry_flag <= carryCopy_next;
      end
   end

endmodule // serial_bit_test_even

/* testbench/serial_bit_test_even_properties.sv */
// timing properties of the serial bit-test-even sequencer
`timescale 1ns/10ps
module serial_bit_test_even_properties (
   input wire core_clk, // machine clock
   input wire resetn, // async reset, active low
   input wire test_bit_even_op, // start pulse
   input wire [4:0] instruction_index_field, // selected bit index
   input wire [14:0] pcIn, // program counter at start
   input wire [23:0] acc_reg, // accumulator
   input wire test_flag, // test flag
   input wire [4:0] shiftCount_reg, // shift counter
   input wire [14:0] pc_reg, // program counter
   input wire busy_reg, // instruction running
   input wire done_reg, // completion pulse
   input wire serial_carry_flag // adder carry copy
);
   default clocking @(posedge core_clk); endclocking
   default disable iff (!resetn);
   wire go = test_bit_even_op && !busy_reg;
   property p_ld; go |=> shiftCount_reg == ~$past(instruction_index_field); endproperty
   property p_clr; go |=> !test_flag; endproperty
   property p_cy; busy_reg |-> serial_carry_flag; endproperty
   property p_inc; busy_reg |=> shiftCount_reg == 5'($past(shiftCount_reg) + 5'h01); endproperty
   property p_rot; busy_reg |=> acc_reg == {$past(acc_reg[0]), $past(acc_reg[23:1])}; endproperty
   property p_hit; busy_reg && shiftCount_reg == 5'h1f |=> test_flag == !$past(acc_reg[0]);
   endproperty
   property p_end; go |-> ##25 done_reg; endproperty
   property p_pc; go |-> ##25 pc_reg == 15'($past(pcIn, 25) + 15'h0001); endproperty
   property p_keep; go |-> ##25 acc_reg == $past(acc_reg, 25); endproperty
   property p_range; go && instruction_index_field > 5'h17 |-> ##25 !test_flag; endproperty
   a_ld: assert property (p_ld) else $error("load");
   a_clr: assert property (p_clr) else $error("clear");
   a_cy: assert property (p_cy) else $error("carry");
   a_inc: assert property (p_inc) else $error("count");
   a_rot: assert property (p_rot) else $error("rotate");
   a_hit: assert property (p_hit) else $error("flag");
   a_end: assert property (p_end) else $error("length");
   a_pc: assert property (p_pc) else $error("pc");
   a_keep: assert property (p_keep) else $error("accumulator changed");
   a_range: assert property (p_range) else $error("flag set for missing bit");
   c_go: cover property (go);
   c_set: cover property (done_reg && test_flag);
   c_clr: cover property (done_reg && !test_flag);
endmodule // serial_bit_test_even_properties

/* testbench/serial_bit_test_even_bench.sv */
// self-checking bench for the serial bit-test-even sequencer
`timescale 1ns/10ps
module serial_bit_test_even_bench;
   logic core_clk = 1'b0, resetn = 1'b0, test_bit_even_op = 1'b0, accLoad = 1'b0;
   logic [4:0] instruction_index_field = 5'h00, shiftCount_reg;
   logic [23:0] accIn = 24'h000000, acc_reg;
   logic [14:0] pcIn = 15'h0000, pc_reg;
   logic test_flag, busy_reg, done_reg, serial_carry_flag;
   int error_cnt = 0, total_checks = 0;
   always #25 core_clk = ~core_clk;
   serial_bit_test_even dut (
      .core_clk(core_clk),
      .resetn(resetn),
      .test_bit_even_op(test_bit_even_op),
      .instruction_index_field(instruction_index_field),
      .accLoad(accLoad),
      .accIn(accIn),
      .pcIn(pcIn),
      .acc_reg(acc_reg),
      .test_flag(test_flag),
      .shiftCount_reg(shiftCount_reg),
      .pc_reg(pc_reg),
      .busy_reg(busy_reg),
      .done_reg(done_reg),
      .serial_carry_flag(serial_carry_flag)
   );
   task chk(input string n, input logic [23:0] e, g);
      total_checks++;
      if (g !== e) begin
         error_cnt++;
         $display("FAIL %s expected %h seen %h", n, e, g);
      end
   endtask
   task stop_test;
      $display("checks %0d errors %0d", total_checks, error_cnt);
      if (error_cnt == 0 && total_checks > 0) $display("Regression OK");
      else $display("Regression broken");
      $finish;
   endtask
   task run(input logic [4:0] z, input logic [23:0] a, input logic f);
      int i;
      accIn = a;
      accLoad = 1'b1;
      @(posedge core_clk) #1;
      accLoad = 1'b0;
      test_bit_even_op = 1'b1;
      instruction_index_field = z;
      pcIn = {10'h000, z};
      @(posedge core_clk) #1;
      test_bit_even_op = 1'b0;
      for (i = 0; i < 40 && done_reg !== 1'b1; i++) @(posedge core_clk) #1;
      if (i == 40) begin
         chk("done", 24'h000001, done_reg);
         stop_test;
      end else begin
         chk("flag", {23'h000000, f}, test_flag);
         chk("acc", a, acc_reg);
         chk("pc", {9'h000, 10'h000, z} + 24'h000001, pc_reg);
         chk("count", 5'(5'h17 - z), shiftCount_reg);
         chk("cycles", 24'h000018, 24'(i));
         chk("busy", 24'h000000, busy_reg);
         chk("carry", 24'h000001, serial_carry_flag);
      end
   endtask
   task sc_zero;
      run(5'h00, 24'hfffffe, 1'b1);
   endtask
   task sc_one;
      run(5'h17, 24'h800000, 1'b0);
   endtask
   task sc_range;
      run(5'h18, 24'h000000, 1'b0);
   endtask
   task sc_reset;
      test_bit_even_op = 1'b1;
      instruction_index_field = 5'h03;
      @(posedge core_clk) #1;
      test_bit_even_op = 1'b0;
      repeat (5) @(posedge core_clk) #1;
      resetn = 1'b0;
      @(posedge core_clk) #1;
      chk("busy", 24'h000000, busy_reg);
      chk("flag", 24'h000000, test_flag);
      resetn = 1'b1;
   endtask
   initial begin
      repeat (3) @(posedge core_clk);
      #1 resetn = 1'b1;
      sc_zero;
      sc_one;
      sc_reset;
      sc_range;
      stop_test;
   end
endmodule // serial_bit_test_even_bench
bind serial_bit_test_even serial_bit_test_even_properties props (
   .core_clk(core_clk),
   .resetn(resetn),
   .test_bit_even_op(test_bit_even_op),
   .instruction_index_field(instruction_index_field),
   .pcIn(pcIn),
   .acc_reg(acc_reg),
   .test_flag(test_flag),
   .shiftCount_reg(shiftCount_reg),
   .pc_reg(pc_reg),
   .busy_reg(busy_reg),
   .done_reg(done_reg),
   .serial_carry_flag(serial_carry_flag)
);
